/* File: dv/model_specific_register_bank_tb_top.sv */
// Self-checking testbench for the model-specific register bank
`default_nettype none

`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("Error t=%0t value %h expected %h", $time, (got), (exp)); \
      end \
   end

module model_specific_register_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import msr_bank_pkg::*;

   // ----------------------------------------
   // Design under test
   // ----------------------------------------
   // Core select wider than needed so a non-existent core can be requested
   localparam int unsigned N_CORES = 2;
   localparam int unsigned CW      = 2;
   // op takes one request every three cycles, so back-to-back counter reads lie this far apart
   localparam int unsigned OP_GAP  = 3;

   logic                         clk;
   logic                         rst_n;
   logic [CW-1:0]                req_core;
   logic                         rd_req;
   logic                         wr_req;
   logic [ADDR_W-1:0]            req_addr;
   logic [DATA_W-1:0]            wr_data;
   logic [PLAT_FLAG_W-1:0]       flag_strap;
   logic [N_CORES*RATIO_W-1:0]   ratio_strap;
   logic                         rd_valid;
   logic [DATA_W-1:0]            rd_data;
   logic                         access_fault;
   logic                         data_chk;
   logic                         resp_chk;
   int                           n_mismatch;
   int                           samples_checked;
   logic [63:0]                  words[N_CORES][4];
   logic [31:0]                  rw_addr[4];
   logic [63:0]                  d;
   logic [63:0]                  a;
   logic [63:0]                  b;
   logic [N_CORES*RATIO_W-1:0]   r;

   msr_bank #(
      .NUM_CORES (N_CORES),
      .CORE_W    (CW)
   ) DUT (
      .clk                 (clk),
      .rst_n               (rst_n),
      .req_core            (req_core),
      .rd_req              (rd_req),
      .wr_req              (wr_req),
      .req_addr            (req_addr),
      .wr_data             (wr_data),
      .platform_flag_strap (flag_strap),
      .bus_ratio_strap     (ratio_strap),
      .rd_valid            (rd_valid),
      .rd_data             (rd_data),
      .access_fault        (access_fault),
      .data_err_check_en   (data_chk),
      .resp_err_check_en   (resp_chk)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------
   // Expectations and bus tasks
   // ----------------------------------------
   function automatic logic [63:0] exp_plat(input logic [2:0] f, input logic [4:0] ratio);
      exp_plat = 64'h0;
      exp_plat[52:50] = f;
      exp_plat[12:8] = ratio;
   endfunction

   function automatic logic [63:0] exp_pwr(input logic [63:0] wd);
      exp_pwr = 64'h0;
      exp_pwr[1] = wd[1];
      exp_pwr[2] = wd[2];
   endfunction

   // Fixed two-cycle answer latency, so no open wait is needed
   task automatic op(input logic [CW-1:0] core, input logic rd, input logic wr, input logic [31:0] addr,
                     input logic [63:0] data, output logic [63:0] rdat, output logic flt, output logic vld);
      @(posedge clk);
      #1;
      req_core = core;
      rd_req = rd;
      wr_req = wr;
      req_addr = addr;
      wr_data = data;
      @(posedge clk);
      #1;
      rd_req = 1'b0;
      wr_req = 1'b0;
      // Answer stands for one cycle only, from the first edge after the taking edge
      @(posedge clk);
      #1;
      rdat = rd_data;
      flt = access_fault;
      vld = rd_valid;
   endtask

   task automatic rd(input logic [CW-1:0] core, input logic [31:0] addr, input logic eflt, output logic [63:0] q);
      logic f;
      logic v;
      op(core, 1'b1, 1'b0, addr, 64'h0, q, f, v);
      `CHK(v, 1'b1)
      `CHK(f, eflt)
   endtask

   task automatic rd_chk(input logic [CW-1:0] core, input logic [31:0] addr, input logic [63:0] e, input logic eflt);
      logic [63:0] q;
      rd(core, addr, eflt, q);
      `CHK(q, e)
   endtask

   task automatic wr_chk(input logic [CW-1:0] core, input logic [31:0] addr, input logic [63:0] wd, input logic eflt);
      logic [63:0] q;
      logic f;
      logic v;
      op(core, 1'b0, 1'b1, addr, wd, q, f, v);
      `CHK(f, eflt)
      `CHK(v, 1'b0)
   endtask

   task automatic do_reset(input logic [2:0] f, input logic [N_CORES*RATIO_W-1:0] ratio);
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      flag_strap = f;
      ratio_strap = ratio;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
   endtask

   task automatic give_verdict();
      $display("Counts: %0d compared, %0d mismatched", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Guards against a hang anywhere in the sequence
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("Error t=%0t run limit reached", $time);
      give_verdict();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      req_core = '0;
      rd_req = 1'b0;
      wr_req = 1'b0;
      req_addr = '0;
      wr_data = '0;
      flag_strap = '0;
      ratio_strap = '0;
      n_mismatch = 0;
      samples_checked = 0;
      rw_addr = '{ADDR_MC_ADDR, ADDR_MC_TYPE, ADDR_MON_SIZE, ADDR_APIC_BASE};
      void'($urandom(32'h497C));
      // Every flag code; straps change after reset and must be ignored
      for (int f = 0; f < 8; f++) begin
         r = (N_CORES*RATIO_W)'($urandom());
         do_reset(3'(f), r);
         flag_strap = ~3'(f);
         ratio_strap = ~r;
         for (int c = 0; c < N_CORES; c++) begin
            rd_chk(CW'(c), ADDR_PLATFORM, exp_plat(3'(f), r[c*RATIO_W +: RATIO_W]), 1'b0);
         end
      end
      wr_chk(2'd0, ADDR_PLATFORM, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
      rd_chk(2'd0, ADDR_PLATFORM, exp_plat(3'h7, r[4:0]), 1'b0);
      $display("test platform_id done");
      `CHK(data_chk, 1'b0)
      `CHK(resp_chk, 1'b0)
      rd_chk(2'd1, ADDR_POWERON, 64'h0, 1'b0);
      for (int k = 0; k < 3; k++) begin
         foreach (words[c, i]) begin
            words[c][i] = {$urandom(), $urandom()};
            wr_chk(CW'(c), rw_addr[i], words[c][i], 1'b0);
         end
         foreach (words[c, i]) begin
            rd_chk(CW'(c), rw_addr[i], words[c][i], 1'b0);
         end
      end
      $display("test per_core_words done");
      // Written from one core and read from the other
      for (int k = 0; k < 8; k++) begin
         d = (k == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : (k == 1) ? 64'h0 : {$urandom(), $urandom()};
         wr_chk(CW'(k % 2), ADDR_POWERON, d, 1'b0);
         `CHK(data_chk, d[1])
         `CHK(resp_chk, d[2])
         rd_chk(CW'((k + 1) % 2), ADDR_POWERON, exp_pwr(d), 1'b0);
      end
      $display("test poweron_config done");
      rd_chk(2'd0, 32'h0000_0002, 64'h0, 1'b1);
      wr_chk(2'd1, 32'h0000_0003, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
      rd_chk(2'd3, ADDR_MC_ADDR, 64'h0, 1'b1);
      wr_chk(2'd3, ADDR_MC_ADDR, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
      rd_chk(2'd1, ADDR_MC_ADDR, words[1][0], 1'b0);
      $display("test refused_access done");
      // Load each core's counter, then read it twice a fixed gap apart
      for (int c = 0; c < N_CORES; c++) begin
         d = {$urandom(), $urandom()};
         wr_chk(CW'(c), ADDR_TSC, d, 1'b0);
         rd(CW'(c), ADDR_TSC, 1'b0, a);
         rd(CW'(c), ADDR_TSC, 1'b0, b);
         `CHK(a - d, 64'(OP_GAP - 1))
         `CHK(b - a, 64'(OP_GAP))
      end
      $display("test timestamp done");
      give_verdict();
   end

endmodule

`default_nettype wire

/* File: include/msr_bank_pkg.sv */
// Constants shared by the model-specific register bank and its word store
//
// Overview of operation
// - Every register is read by the model register read instruction and, except the read-only platform register, written by the write instruction, by address.
// - A per-core register exists once for each core and affects only the core that owns it.
// - A shared register exists once and its setting governs both cores together.
// - The platform flag info register shows a read-only three-bit flag in bits 52:50, other bits reserved.
// - The platform register at address 17H is readable so software can find slot data and pick its microcode update.
// - The per-core bus ratio limit reads in bits 12:8 of the same address, other bits reserved.
// - The hard power-on config register at 2AH is shared, writes set features and reads give the current setting.
// - Bit 1 of the power-on config register enables data error checking when set.
// - Bit 2 of the power-on config register enables response error checking and redundancy error observation.
`default_nettype none

package msr_bank_pkg;

   // ----------------------------------------
   // Access widths
   // ----------------------------------------
   localparam int unsigned ADDR_W         = 32;
   localparam int unsigned DATA_W         = 64;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [31:0] ADDR_MC_ADDR    = 32'h0000_0000;
   localparam logic [31:0] ADDR_MC_TYPE    = 32'h0000_0001;
   localparam logic [31:0] ADDR_MON_SIZE   = 32'h0000_0006;
   localparam logic [31:0] ADDR_TSC        = 32'h0000_0010;
   localparam logic [31:0] ADDR_PLATFORM   = 32'h0000_0017;
   localparam logic [31:0] ADDR_APIC_BASE  = 32'h0000_001B;
   localparam logic [31:0] ADDR_POWERON    = 32'h0000_002A;

   // ----------------------------------------
   // Slots of the per-core word store
   // ----------------------------------------
   localparam int unsigned SLOT_MC_ADDR    = 0;
   localparam int unsigned SLOT_MC_TYPE    = 1;
   localparam int unsigned SLOT_MON_SIZE   = 2;
   localparam int unsigned SLOT_APIC_BASE  = 3;
   localparam int unsigned SLOTS_PER_CORE  = 4;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned PLAT_FLAG_LSB   = 50;
   localparam int unsigned PLAT_FLAG_W     = 3;
   localparam int unsigned RATIO_LSB       = 8;
   localparam int unsigned RATIO_W         = 5;
   localparam int unsigned PWR_DATA_CHK    = 1;
   localparam int unsigned PWR_RESP_CHK    = 2;

   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [63:0] POWERON_RESET   = 64'h0000_0000_0000_0000;
   localparam logic [63:0] TSC_RESET       = 64'h0000_0000_0000_0000;
   localparam logic [63:0] WORD_RESET      = 64'h0000_0000_0000_0000;
   localparam logic [63:0] TSC_STEP        = 64'h0000_0000_0000_0001;
   localparam int unsigned RD_LATENCY      = 2;

endpackage

`default_nettype wire

/* File: rtl/msr_bank.sv */
// Model-specific register bank shared by the cores of one processor
`default_nettype none

module msr_bank #(
   parameter int unsigned NUM_CORES = 2,
   parameter int unsigned CORE_W    = 1
) (
   input  wire logic                                           clk,
   input  wire logic                                           rst_n,
   input  wire logic [CORE_W-1:0]                              req_core,
   input  wire logic                                           rd_req,
   input  wire logic                                           wr_req,
   input  wire logic [msr_bank_pkg::ADDR_W-1:0]                req_addr,
   input  wire logic [msr_bank_pkg::DATA_W-1:0]                wr_data,
   input  wire logic [msr_bank_pkg::PLAT_FLAG_W-1:0]           platform_flag_strap,
   input  wire logic [NUM_CORES*msr_bank_pkg::RATIO_W-1:0]     bus_ratio_strap,
   output logic                                                rd_valid,
   output logic      [msr_bank_pkg::DATA_W-1:0]                rd_data,
   output logic                                                access_fault,
   output logic                                                data_err_check_en,
   output logic                                                resp_err_check_en
);
   import msr_bank_pkg::*;

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (NUM_CORES < 1 || NUM_CORES > (1 << CORE_W)) begin : g_bad_param
      $error("msr_bank: NUM_CORES must lie between 1 and 2**CORE_W");
   end

   localparam int unsigned WORDS = NUM_CORES * SLOTS_PER_CORE;
   localparam int unsigned IDX_W = $clog2(WORDS);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [NUM_CORES-1:0][DATA_W-1:0]  tsc;
      logic [PLAT_FLAG_W-1:0]            plat_flag;
      logic [NUM_CORES-1:0][RATIO_W-1:0] ratio;
      logic                              data_chk;
      logic                              resp_chk;
      logic                              rd_p1;
      logic                              use_mem_p1;
      logic                              fault_p1;
      logic [DATA_W-1:0]                 imm_p1;
      logic                              rd_valid;
      logic [DATA_W-1:0]                 rd_data;
      logic                              fault;
   } bank_t;

   bank_t q;
   bank_t d;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic                               core_ok;
   logic                               sel_mem;
   logic                               sel_tsc;
   logic                               sel_plat;
   logic                               sel_pwr;
   logic                               mapped;
   logic                               bad_req;
   int unsigned                        slot;
   logic [IDX_W-1:0]                   mem_idx;
   logic [DATA_W-1:0]                  mem_rdata;
   logic [DATA_W-1:0]                  imm;
   logic [NUM_CORES-1:0][DATA_W-1:0]   tsc_next;

   assign core_ok  = 32'(req_core) < 32'(NUM_CORES);
   assign sel_tsc  = req_addr == ADDR_TSC;
   assign sel_plat = req_addr == ADDR_PLATFORM;
   assign sel_pwr  = req_addr == ADDR_POWERON;

   always_comb begin
      slot    = SLOT_MC_ADDR;
      sel_mem = 1'b1;
      unique case (req_addr)
         ADDR_MC_ADDR:   slot = SLOT_MC_ADDR;
         ADDR_MC_TYPE:   slot = SLOT_MC_TYPE;
         ADDR_MON_SIZE:  slot = SLOT_MON_SIZE;
         ADDR_APIC_BASE: slot = SLOT_APIC_BASE;
         default:        sel_mem = 1'b0;
      endcase
   end

   assign mapped  = sel_mem | sel_tsc | sel_plat | sel_pwr;
   // Unknown core, unknown address, or a write aimed at read-only identity
   assign bad_req = (rd_req | wr_req) & (~core_ok | ~mapped | (wr_req & sel_plat));

   // Each core owns its own block of slots, so a core never reaches a sibling's copy
   assign mem_idx = IDX_W'(32'(req_core) * SLOTS_PER_CORE + slot);

   // ----------------------------------------
   // Plain read-write words
   // ----------------------------------------
   msr_word_store #(
      .WORDS (WORDS),
      .WIDTH (DATA_W)
   ) u_store (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (wr_req & core_ok & sel_mem),
      .waddr (mem_idx),
      .wdata (wr_data),
      .re    (rd_req & core_ok & sel_mem),
      .raddr (mem_idx),
      .rdata (mem_rdata)
   );

   // ----------------------------------------
   // Per-core time-stamp counters
   // ----------------------------------------
   // A write loads the owner's counter only; the others keep counting
   for (genvar c = 0; c < int'(NUM_CORES); c++) begin : g_core
      assign tsc_next[c] = (wr_req && core_ok && sel_tsc && 32'(req_core) == 32'(c)) ?
                           wr_data : q.tsc[c] + TSC_STEP;
   end

   // ----------------------------------------
   // Values read straight from state
   // ----------------------------------------
   always_comb begin
      imm = '0;
      if (core_ok && sel_tsc) begin
         imm = q.tsc[req_core];
      end
      if (core_ok && sel_plat) begin
         imm[PLAT_FLAG_LSB +: PLAT_FLAG_W] = q.plat_flag;
         imm[RATIO_LSB +: RATIO_W]         = q.ratio[req_core];
      end
      if (core_ok && sel_pwr) begin
         imm[PWR_DATA_CHK] = q.data_chk;
         imm[PWR_RESP_CHK] = q.resp_chk;
      end
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Straps are caught while reset is held, so identity is stable from the first request
   always_comb begin
      d = q;
      if (!rst_n) begin
         d              = '0;
         d.plat_flag    = platform_flag_strap;
         d.ratio        = bus_ratio_strap;
         d.data_chk     = POWERON_RESET[PWR_DATA_CHK];
         d.resp_chk     = POWERON_RESET[PWR_RESP_CHK];
         for (int i = 0; i < int'(NUM_CORES); i++) begin
            d.tsc[i] = TSC_RESET;
         end
      end else begin
         d.tsc        = tsc_next;
         d.rd_p1      = rd_req;
         d.use_mem_p1 = rd_req & core_ok & sel_mem;
         d.fault_p1   = bad_req;
         d.imm_p1     = imm;
         // One shared copy, so a write from any core reaches both; other bits are dropped
         if (wr_req && core_ok && sel_pwr) begin
            d.data_chk = wr_data[PWR_DATA_CHK];
            d.resp_chk = wr_data[PWR_RESP_CHK];
         end
         d.rd_valid = q.rd_p1;
         d.rd_data  = q.rd_p1 ? (q.use_mem_p1 ? mem_rdata : q.imm_p1) : '0;
         d.fault    = q.fault_p1;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rd_valid          = q.rd_valid;
   assign rd_data           = q.rd_data;
   assign access_fault      = q.fault;
   // Both cores see the same enable; there is no per-core override
   assign data_err_check_en = q.data_chk;
   assign resp_err_check_en = q.resp_chk;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_read_answer_time: assert property (rd_req |-> ##2 rd_valid)
      else $error("read answer not two cycles after request");

   a_tsc_load_own: assert property (wr_req && core_ok && sel_tsc && req_core == '0
                                    |=> q.tsc[0] == $past(wr_data) ##1 q.tsc[0] == $past(wr_data, 2) + TSC_STEP)
      else $error("counter write did not load and resume counting");

   a_tsc_core_private: assert property (wr_req && sel_tsc && req_core == '0 && NUM_CORES > 1
                                        |=> q.tsc[NUM_CORES-1] == $past(q.tsc[NUM_CORES-1]) + TSC_STEP)
      else $error("counter write leaked into another core");

   a_pwr_shared_read: assert property (rd_req && core_ok && sel_pwr && !wr_req
                                       |-> ##2 rd_data == (DATA_W'({resp_err_check_en, data_err_check_en}) << PWR_DATA_CHK))
      else $error("power-on config read differs from shared enables");

   a_data_chk_write: assert property (wr_req && core_ok && sel_pwr
                                      |=> data_err_check_en == $past(wr_data[PWR_DATA_CHK]))
      else $error("data check enable not written");

   a_resp_chk_write: assert property (wr_req && core_ok && sel_pwr
                                      |=> resp_err_check_en == $past(wr_data[PWR_RESP_CHK]))
      else $error("response check enable not written");

   a_pwr_hold_other: assert property ((!wr_req || !sel_pwr) |=> $stable(q.data_chk) && $stable(q.resp_chk))
      else $error("power-on config changed without a write");

   a_plat_fields: assert property (rd_req && core_ok && sel_plat
                                   |-> ##2 rd_data[PLAT_FLAG_LSB +: PLAT_FLAG_W] == q.plat_flag)
      else $error("platform flag field wrong on read");

   a_plat_readonly: assert property (wr_req && sel_plat |=> $stable(q.plat_flag) && $stable(q.ratio) ##1 access_fault)
      else $error("write to platform register not refused");

   a_ratio_reserved: assert property (rd_req && core_ok && sel_plat
                                      |-> ##2 (rd_data & ~((DATA_W'(8'hFF) >> (8 - RATIO_W)) << RATIO_LSB)
                                               & ~((DATA_W'(8'hFF) >> (8 - PLAT_FLAG_W)) << PLAT_FLAG_LSB)) == '0)
      else $error("platform register reserved bits not zero");

   a_unmapped_zero: assert property ((rd_req && !mapped) |-> ##2 access_fault && rd_data == '0)
      else $error("unmapped read not refused with zero data");

endmodule

`default_nettype wire

/* File: rtl/msr_word_store.sv */
// Small word store holding the plain read-write registers of every core
`default_nettype none

module msr_word_store #(
   parameter int unsigned WORDS = 8,
   parameter int unsigned WIDTH = 64
) (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       we,
   input  wire logic [$clog2(WORDS)-1:0]   waddr,
   input  wire logic [WIDTH-1:0]           wdata,
   input  wire logic                       re,
   input  wire logic [$clog2(WORDS)-1:0]   raddr,
   output logic      [WIDTH-1:0]           rdata
);
   import msr_bank_pkg::*;

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (WORDS < 2 || WIDTH > DATA_W) begin : g_bad_param
      $error("msr_word_store: WORDS must be at least 2 and WIDTH at most DATA_W");
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [WORDS-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rdata;
   } store_t;

   store_t q;
   store_t d;

   // Read sees the old word when it meets a write to the same slot
   always_comb begin
      d = q;
      if (!rst_n) begin
         d = '0;
         for (int i = 0; i < int'(WORDS); i++) begin
            d.mem[i] = WORD_RESET[WIDTH-1:0];
         end
      end else begin
         if (we) begin
            d.mem[waddr] = wdata;
         end
         if (re) begin
            d.rdata = q.mem[raddr];
         end
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   assign rdata = q.rdata;

endmodule

`default_nettype wire
